/* verilog/pwe_pkg.sv */
package pwe_pkg;
  // Clock and timing
  localparam int CLK_MHZ = 125;
  localparam int LOAD_WINDOW_US = 100;
  localparam int LOAD_WINDOW_CYC = (LOAD_WINDOW_US * CLK_MHZ);
  localparam int WRITE_TYP_MS = 5;
  localparam int WRITE_TYP_CYC = (WRITE_TYP_MS * 1000 * CLK_MHZ);
  localparam int POLL_GAP_CYC = 16;
  localparam int PULSE_CYC = 12;
  localparam int SETUP_CYC = 2;
  localparam int READ_CYC = 10;
  localparam int RECHECK_READS = 2;
  localparam int PAGE_BYTES = 128;
  localparam int PAGE_LSB = 7;
  // Command pairs
  localparam logic [15:0] CMD_ADDR_A = 16'h5555;
  localparam logic [15:0] CMD_ADDR_B = 16'h2AAA;
  localparam logic [7:0] CMD_DATA_A = 8'hAA;
  localparam logic [7:0] CMD_DATA_B = 8'h55;
  localparam logic [7:0] CMD_WRITE = 8'hA0;
  localparam logic [7:0] CMD_ERASE1 = 8'h80;
  localparam logic [7:0] CMD_ERASE2 = 8'h10;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  // Host operations
  typedef enum logic [1:0] {
    OP_READ  = 2'h0,
    OP_WRITE = 2'h1,
    OP_ERASE = 2'h2
  } pwe_op_t;
endpackage

/* verilog/pwe_bus_cycle.sv */
`timescale 1ns/1ps
// One strobe cycle on the device pins: read or byte load
module pwe_bus_cycle
  import pwe_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Request
  input  wire logic        start,
  input  wire logic        isWrite,
  input  wire logic [15:0] addrIn,
  input  wire logic [7:0]  dataIn,
  output logic             done,
  output logic [7:0]       readData,
  // Pins
  output logic [15:0]      memAddr,
  output logic             chipSelectN,
  output logic             outputGateN,
  output logic             writeStrobeN,
  output logic [7:0]       dqOut,
  output logic             dqOe,
  input  wire logic [7:0]  dqIn
);
  typedef enum logic [1:0] {
    BC_IDLE   = 2'h0,
    BC_SETUP  = 2'h1,
    BC_STROBE = 2'h3,
    BC_HOLD   = 2'h2
  } pwe_bc_state_t;

  pwe_bc_state_t stateReg, stateNext;
  logic [4:0]  cntReg, cntNext;
  logic        wrReg, wrNext;
  logic [15:0] addrReg, addrNext;
  logic [7:0]  dataReg, dataNext, rdReg, rdNext;
  logic        csReg, csNext, ogReg, ogNext, wsReg, wsNext, oeReg, oeNext, doneReg, doneNext;

  always_comb begin
    stateNext = stateReg;
    cntNext = cntReg;
    wrNext = wrReg;
    addrNext = addrReg;
    dataNext = dataReg;
    rdNext = rdReg;
    csNext = csReg;
    ogNext = ogReg;
    wsNext = wsReg;
    oeNext = oeReg;
    doneNext = 1'b0;
    case (stateReg)
      BC_IDLE: begin
        if (start) begin
          wrNext = isWrite;
          addrNext = addrIn;
          dataNext = dataIn;
          oeNext = isWrite;
          cntNext = 5'(SETUP_CYC);
          stateNext = BC_SETUP;
        end
      end
      BC_SETUP: begin
        if (cntReg == 5'h0) begin
          csNext = 1'b0; // [RL1]
          ogNext = wrReg; // [RL1] [RL6]
          wsNext = ~wrReg; // [RL7]
          cntNext = wrReg ? 5'(PULSE_CYC) : 5'(READ_CYC);
          stateNext = BC_STROBE;
        end else begin
          cntNext = cntReg - 5'h1;
        end
      end
      BC_STROBE: begin
        if (cntReg == 5'h0) begin
          if (!wrReg) begin
            rdNext = dqIn;
          end
          csNext = 1'b1; // [RL8]
          ogNext = 1'b1;
          wsNext = 1'b1; // [RL8]
          cntNext = 5'(SETUP_CYC);
          stateNext = BC_HOLD;
        end else begin
          cntNext = cntReg - 5'h1;
        end
      end
      BC_HOLD: begin
        if (cntReg == 5'h0) begin
          oeNext = 1'b0;
          doneNext = 1'b1;
          stateNext = BC_IDLE;
        end else begin
          cntNext = cntReg - 5'h1;
        end
      end
      default: stateNext = BC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      stateReg <= BC_IDLE;
      cntReg <= 5'h0;
      wrReg <= 1'b0;
      addrReg <= 16'h0;
      dataReg <= 8'h0;
      rdReg <= 8'h0;
      csReg <= 1'b1;
      ogReg <= 1'b1;
      wsReg <= 1'b1;
      oeReg <= 1'b0;
      doneReg <= 1'b0;
    end else begin
      stateReg <= stateNext;
      cntReg <= cntNext;
      wrReg <= wrNext;
      addrReg <= addrNext;
      dataReg <= dataNext;
      rdReg <= rdNext;
      csReg <= csNext;
      ogReg <= ogNext;
      wsReg <= wsNext;
      oeReg <= oeNext;
      doneReg <= doneNext;
    end
  end

  assign done = doneReg;
  assign readData = rdReg;
  assign memAddr = addrReg;
  assign chipSelectN = csReg;
  assign outputGateN = ogReg;
  assign writeStrobeN = wsReg;
  assign dqOut = dataReg;
  assign dqOe = oeReg;

  AST_DRIVE_NOT_READ: assert property (@(posedge core_clk) disable iff (reset)
    dqOe |-> outputGateN) else $error("Data driven while output gate low"); // [RL1]
  AST_STROBE_LEN: assert property (@(posedge core_clk) disable iff (reset)
    $fell(writeStrobeN) |-> !writeStrobeN [*8]) else $error("Write strobe too short"); // [RL6]
  AST_CS_WITH_STROBE: assert property (@(posedge core_clk) disable iff (reset)
    !writeStrobeN |-> !chipSelectN && dqOe) else $error("Strobe without select or data"); // [RL7]
  AST_ADDR_STABLE: assert property (@(posedge core_clk) disable iff (reset)
    !chipSelectN |-> $stable(memAddr)) else $error("Address moved during select"); // [RL8]
endmodule

/* verilog/pwe_host.sv */
`timescale 1ns/1ps
// Notes on behaviour
// [RL1] Reads drive select and output gate low together.
// [RL2] Device floats data when select or gate is high; host drives only on loads.
// [RL3] Select high leaves the device idle between cycles.
// [RL4] Protect command sets global lock; repeats unlock only the current page.
// [RL5] Host precedes every page write with the three-byte protect command.
// [RL6] Command and page loads use identical strobe timing.
// [RL7] Device takes address at the later falling select/strobe edge.
// [RL8] Device takes data at the earlier rising select/strobe edge.
// [RL9] Load timeout starts a write that runs about 5 ms.
// [RL10] One to 128 bytes are loaded per page.
// [RL11] Only poll and toggle bits are meaningful during the write.
// [RL12] Whole page buffer programs at once.
// [RL13] All bytes of one page share address bits 15 to 7.
// [RL14] Target page follows last loaded byte.
// [RL15] Unloaded page bytes become FF.
// [RL16] Each next byte must follow within 100 us.
// [RL17] No strobe within 100 us ends the page load.
// [RL18] Reloading a location overwrites it in the buffer.
// [RL19] Six-byte sequence starts chip erase to all ones.
// [RL20] During erase only the toggle bit is valid.
// [RL21] Status valid from the rising strobe that starts the write.
// [RL22] On conflicting status, read twice more; both must be valid.
// [RL23] Write command is 5555/AA, 2AAA/55, 5555/A0 then data.
// [RL24] Poll bit reads inverted until the write completes.
// [RL25] Toggle bit alternates during the write and stops after.
// [RL26] Lock is clear as delivered.
// [RL27] Device times itself on its own oscillator.
module pwe_host
  import pwe_pkg::*;
(
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               reset,
  // Command port
  input  wire logic               cmdValid,
  input  wire pwe_pkg::pwe_op_t   cmdOp,
  input  wire logic [15:0]        cmdAddr,
  input  wire logic [7:0]         cmdData,
  input  wire logic               cmdLast,
  output logic                    cmdReady,
  output logic                    rspValid,
  output logic [7:0]              rspData,
  output logic                    busy,
  output logic                    pageError,
  // Device pins
  output logic [15:0]             memAddr,
  output logic                    chipSelectN,
  output logic                    outputGateN,
  output logic                    writeStrobeN,
  output logic [7:0]              dqOut,
  output logic                    dqOe,
  input  wire logic [7:0]         dqIn
);
  typedef enum logic [2:0] {
    HS_IDLE  = 3'h0,
    HS_CMD   = 3'h1,
    HS_LOAD  = 3'h3,
    HS_WAIT  = 3'h2,
    HS_POLL  = 3'h6,
    HS_GAP   = 3'h7,
    HS_READ  = 3'h5
  } pwe_state_t;

  function automatic logic [15:0] seqAddr(input logic [2:0] idx);
    seqAddr = (idx == 3'h1 || idx == 3'h4) ? CMD_ADDR_B : CMD_ADDR_A;
  endfunction

  function automatic logic [7:0] seqData(input logic [2:0] idx, input logic erase);
    case (idx)
      3'h0, 3'h3: seqData = CMD_DATA_A;
      3'h1, 3'h4: seqData = CMD_DATA_B;
      3'h2:       seqData = erase ? CMD_ERASE1 : CMD_WRITE;
      default:    seqData = CMD_ERASE2;
    endcase
  endfunction

  pwe_state_t  stateReg, stateNext;
  logic [2:0]  seqReg, seqNext;
  logic        eraseReg, eraseNext, lastReg, lastNext;
  logic [15:0] addrReg, addrNext;
  logic [7:0]  dataReg, dataNext, prevReg, prevNext;
  logic [8:0]  pageReg, pageNext;
  logic [7:0]  countReg, countNext;
  logic [1:0]  agreeReg, agreeNext;
  logic [4:0]  gapReg, gapNext;
  logic        readyReg, readyNext, rspVReg, rspVNext, busyReg, busyNext, errReg, errNext;
  logic        bcStart, bcWrite, bcDone;
  logic [15:0] bcAddr;
  logic [7:0]  bcData, bcRead;

  pwe_bus_cycle u_cycle (
    .core_clk     (core_clk),
    .reset        (reset),
    .start        (bcStart),
    .isWrite      (bcWrite),
    .addrIn       (bcAddr),
    .dataIn       (bcData),
    .done         (bcDone),
    .readData     (bcRead),
    .memAddr      (memAddr),
    .chipSelectN  (chipSelectN),
    .outputGateN  (outputGateN),
    .writeStrobeN (writeStrobeN),
    .dqOut        (dqOut),
    .dqOe         (dqOe),
    .dqIn         (dqIn)
  );

  always_comb begin
    stateNext = stateReg;
    seqNext = seqReg;
    eraseNext = eraseReg;
    lastNext = lastReg;
    addrNext = addrReg;
    dataNext = dataReg;
    prevNext = prevReg;
    pageNext = pageReg;
    countNext = countReg;
    agreeNext = agreeReg;
    gapNext = gapReg;
    readyNext = 1'b0;
    rspVNext = 1'b0;
    busyNext = busyReg;
    errNext = errReg;
    bcStart = 1'b0;
    bcWrite = 1'b1;
    bcAddr = addrReg;
    bcData = dataReg;
    case (stateReg)
      HS_IDLE: begin
        readyNext = !readyReg;
        busyNext = 1'b0;
        if (cmdValid && readyReg) begin
          addrNext = cmdAddr;
          dataNext = cmdData;
          lastNext = cmdLast;
          busyNext = 1'b1;
          seqNext = 3'h0;
          countNext = 8'h0;
          errNext = 1'b0;
          eraseNext = (cmdOp == OP_ERASE);
          pageNext = cmdAddr[15:PAGE_LSB];
          if (cmdOp == OP_READ) begin
            stateNext = HS_READ;
            bcStart = 1'b1;
            bcWrite = 1'b0;
            bcAddr = cmdAddr;
          end else begin
            stateNext = HS_CMD; // [RL5]
          end
        end
      end
      HS_CMD: begin
        bcAddr = seqAddr(seqReg); // [RL23]
        bcData = seqData(seqReg, eraseReg); // [RL19]
        bcStart = 1'b1;
        stateNext = HS_WAIT;
      end
      HS_WAIT: begin
        if (bcDone) begin
          if (seqReg != 3'h7) begin
            seqNext = seqReg + 3'h1;
            if ((!eraseReg && seqReg == 3'h2) || (eraseReg && seqReg == 3'h5)) begin
              seqNext = 3'h7;
              stateNext = eraseReg ? HS_GAP : HS_LOAD;
              gapNext = 5'(POLL_GAP_CYC);
              agreeNext = 2'h0;
            end else begin
              stateNext = HS_CMD; // [RL6]
            end
          end else if (lastReg || countReg == 8'(PAGE_BYTES)) begin
            stateNext = HS_GAP; // [RL9] [RL17]
            gapNext = 5'(POLL_GAP_CYC);
            prevNext = dataReg;
            agreeNext = 2'h0;
          end else begin
            readyNext = 1'b1; // [RL16]
            stateNext = HS_LOAD;
          end
        end
      end
      HS_LOAD: begin
        if (countReg == 8'h0) begin
          stateNext = HS_WAIT;
          bcStart = 1'b1;
          countNext = 8'h1;
        end else if (cmdValid && readyReg) begin
          if (cmdAddr[15:PAGE_LSB] != pageReg) begin
            errNext = 1'b1; // [RL13]
          end
          addrNext = {pageReg, cmdAddr[PAGE_LSB-1:0]}; // [RL13] [RL14]
          dataNext = cmdData; // [RL18]
          lastNext = cmdLast;
          countNext = countReg + 8'h1; // [RL10]
          bcAddr = {pageReg, cmdAddr[PAGE_LSB-1:0]};
          bcData = cmdData;
          bcStart = 1'b1;
          stateNext = HS_WAIT;
        end else begin
          readyNext = 1'b1;
        end
      end
      HS_GAP: begin
        if (gapReg == 5'h0) begin
          bcStart = 1'b1;
          bcWrite = 1'b0; // [RL11]
          stateNext = HS_POLL;
        end else begin
          gapNext = gapReg - 5'h1;
        end
      end
      HS_POLL: begin
        if (bcDone) begin
          prevNext = bcRead;
          gapNext = 5'(POLL_GAP_CYC);
          stateNext = HS_GAP;
          if (bcRead[TOGGLE_BIT] == prevReg[TOGGLE_BIT] &&
              (eraseReg || bcRead[POLL_BIT] == dataReg[POLL_BIT])) begin // [RL20] [RL24] [RL25]
            agreeNext = agreeReg + 2'h1;
            if (agreeReg == 2'(RECHECK_READS)) begin
              stateNext = HS_IDLE; // [RL22]
              rspVNext = 1'b1;
              busyNext = 1'b0;
            end
          end else begin
            agreeNext = 2'h0; // [RL21]
          end
        end
      end
      HS_READ: begin
        if (bcDone) begin
          dataNext = bcRead; // [RL1]
          rspVNext = 1'b1;
          busyNext = 1'b0;
          stateNext = HS_IDLE;
        end
      end
      default: stateNext = HS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      stateReg <= HS_IDLE;
      seqReg <= 3'h0;
      eraseReg <= 1'b0;
      lastReg <= 1'b0;
      addrReg <= 16'h0;
      dataReg <= ERASED_BYTE;
      prevReg <= 8'h0;
      pageReg <= 9'h0;
      countReg <= 8'h0;
      agreeReg <= 2'h0;
      gapReg <= 5'h0;
      readyReg <= 1'b0;
      rspVReg <= 1'b0;
      busyReg <= 1'b0;
      errReg <= 1'b0;
    end else begin
      stateReg <= stateNext;
      seqReg <= seqNext;
      eraseReg <= eraseNext;
      lastReg <= lastNext;
      addrReg <= addrNext;
      dataReg <= dataNext;
      prevReg <= prevNext;
      pageReg <= pageNext;
      countReg <= countNext;
      agreeReg <= agreeNext;
      gapReg <= gapNext;
      readyReg <= readyNext;
      rspVReg <= rspVNext;
      busyReg <= busyNext;
      errReg <= errNext;
    end
  end

  assign cmdReady = readyReg;
  assign rspValid = rspVReg;
  assign rspData = dataReg;
  assign busy = busyReg;
  assign pageError = errReg;

  AST_PAGE_SAME: assert property (@(posedge core_clk) disable iff (reset)
    !writeStrobeN && seqReg == 3'h7 |-> memAddr[15:PAGE_LSB] == pageReg)
    else $error("Page bits changed inside a page"); // [RL13]
  AST_CMD_FIRST: assert property (@(posedge core_clk) disable iff (reset)
    $fell(writeStrobeN) && seqReg == 3'h0 |-> memAddr == CMD_ADDR_A && dqOut == CMD_DATA_A)
    else $error("Write not opened by protect command"); // [RL5]
  AST_PAGE_MAX: assert property (@(posedge core_clk) disable iff (reset)
    countReg <= 8'(PAGE_BYTES)) else $error("Page overfilled"); // [RL10]
  AST_NO_LOAD_POLL: assert property (@(posedge core_clk) disable iff (reset)
    stateReg == HS_POLL |-> writeStrobeN) else $error("Load during status poll"); // [RL11]
endmodule

/* verif/pwe_dev_model.sv */
`timescale 1ns/1ps
// Behavioural page-write memory facing the host pins
module pwe_dev_model #(
  parameter real TMO_NS = 20000.0,
  parameter real WR_NS  = 30000.0
) (
  // Host pins
  input  wire logic [15:0] memAddr,
  input  wire logic        chipSelectN,
  input  wire logic        outputGateN,
  input  wire logic        writeStrobeN,
  input  wire logic [7:0]  dqOut,
  // Driven data
  output logic             devOe,
  output logic [7:0]       devData
);
  logic [7:0]  mem [0:65535];
  logic [7:0]  pageBuf [0:127];
  logic        loaded [0:127];
  logic [22:0] hist [0:5];
  logic [15:0] curA;
  logic [15:0] lastA;
  logic [7:0]  lastD;
  logic        swLock;
  logic        cmdOk;
  logic        loading;
  logic        toggle;
  int          mode;
  realtime     lastRise;
  realtime     doneAt;
  wire         ldSel = !chipSelectN && !writeStrobeN && outputGateN;

  assign devOe = !chipSelectN && !outputGateN;

  function automatic logic seq3(input int k, input logic [7:0] d);
    return hist[k+2] == {15'h5555, 8'hAA} && hist[k+1] == {15'h2AAA, 8'h55}
      && hist[k] == {15'h5555, d};
  endfunction

  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ 8'h5A;
    for (int i = 0; i < 128; i++) loaded[i] = 1'b0;
    for (int i = 0; i < 6; i++) hist[i] = '0;
    swLock = 1'b0;
    cmdOk = 1'b0;
    loading = 1'b0;
    toggle = 1'b0;
    mode = 0;
    lastA = 16'h0000;
    lastD = 8'h00;
    devData = 8'h00;
  end

  always @(posedge ldSel) curA = memAddr;

  always @(negedge ldSel) begin
    if (mode == 0) begin
      for (int i = 5; i > 0; i--) hist[i] = hist[i-1];
      hist[0] = {curA[14:0], dqOut};
      if (seq3(3, 8'h80) && seq3(0, 8'h10)) begin
        loading = 1'b0;
        toggle = 1'b0;
        mode = 2;
        doneAt = $realtime + WR_NS;
      end else if (seq3(0, 8'hA0)) begin
        swLock = 1'b1;
        cmdOk = 1'b1;
        for (int i = 0; i < 128; i++) loaded[i] = 1'b0;
      end else if (cmdOk || !swLock) begin
        pageBuf[curA[6:0]] = dqOut;
        loaded[curA[6:0]] = 1'b1;
        lastA = curA;
        lastD = dqOut;
        loading = 1'b1;
      end
      lastRise = $realtime;
    end
  end

  // Own oscillator, unrelated to the host clock
  always #3 begin
    if (loading && $realtime - lastRise >= TMO_NS) begin
      loading = 1'b0;
      cmdOk = 1'b0;
      toggle = 1'b0;
      mode = 1;
      doneAt = $realtime + WR_NS;
    end
    if (mode != 0 && $realtime >= doneAt) begin
      if (mode == 2) for (int i = 0; i < 65536; i++) mem[i] = 8'hFF;
      else for (int i = 0; i < 128; i++)
        mem[{lastA[15:7], i[6:0]}] = loaded[i] ? pageBuf[i] : 8'hFF;
      for (int i = 0; i < 128; i++) loaded[i] = 1'b0;
      mode = 0;
    end
  end

  // Garbage until access time, then data or status
  always @(posedge devOe) begin
    toggle = !toggle;
    devData = ~mem[memAddr];
    #70;
    if (mode == 1 || loading) devData = {~lastD[7], toggle, ~lastD[5:0]};
    else if (mode == 2) devData = {~devData[7], toggle, devData[5:0]};
    else devData = mem[memAddr];
  end
endmodule

/* verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import pwe_pkg::*;
  logic        core_clk;
  logic        reset;
  logic        cmdValid;
  pwe_op_t     cmdOp;
  logic [15:0] cmdAddr;
  logic [7:0]  cmdData;
  logic        cmdLast;
  logic        cmdReady;
  logic        rspValid;
  logic [7:0]  rspData;
  logic        busy;
  logic        pageError;
  logic [15:0] memAddr;
  logic        chipSelectN;
  logic        outputGateN;
  logic        writeStrobeN;
  logic [7:0]  dqOut;
  logic        dqOe;
  logic [7:0]  dqIn;
  logic        devOe;
  logic [7:0]  devData;
  logic [7:0]  lastBus;
  logic [7:0]  lfsr;
  logic [7:0]  refMem [0:65535];
  int          badCount;
  int          cmpCount;

  pwe_host i_dut (.core_clk, .reset, .cmdValid, .cmdOp, .cmdAddr, .cmdData, .cmdLast,
    .cmdReady, .rspValid, .rspData, .busy, .pageError, .memAddr, .chipSelectN,
    .outputGateN, .writeStrobeN, .dqOut, .dqOe, .dqIn);
  pwe_dev_model i_mem (.memAddr, .chipSelectN, .outputGateN, .writeStrobeN, .dqOut,
    .devOe, .devData);

  // Floating bus shows the inverse of its last driven value
  assign dqIn = dqOe ? dqOut : (devOe ? devData : ~lastBus);
  always @(posedge core_clk) begin
    if (dqOe || devOe) lastBus <= dqIn;
    if (dqOe && devOe) fail("bus clash");
  end

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic giveVerdict();
    $display("Comparisons %0d, mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic fail(input string msg);
    $display("ERROR %0t %s", $time, msg);
    badCount++;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmpCount++;
    if (got !== exp) fail($sformatf("got %h expected %h", got, exp));
  endtask

  task automatic send(input pwe_op_t op, input logic [15:0] a, input logic [7:0] d,
                      input logic last);
    int n;
    cmdOp = op;
    cmdAddr = a;
    cmdData = d;
    cmdLast = last;
    cmdValid = 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (cmdReady !== 1'b1 && n < 20000);
    if (n >= 20000) begin
      fail("command not taken");
      giveVerdict();
    end
    #1 cmdValid = 1'b0;
    @(posedge core_clk);
    #1;
  endtask

  task automatic wait_rsp(input int lim);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
      if (busy === 1'b1 && cmdReady === 1'b1) fail("ready while busy");
    end while (rspValid !== 1'b1 && n < lim);
    if (n >= lim) begin
      fail("no response");
      giveVerdict();
    end
  endtask

  task automatic rd(input logic [15:0] a);
    send(OP_READ, a, 8'h00, 1'b0);
    wait_rsp(200);
    check(rspData, refMem[a]);
  endtask

  task automatic wr_page(input logic [8:0] pg, input logic [6:0] offs [$],
                         input logic [7:0] vals [$], input logic [8:0] lastPg);
    logic [7:0] pb [0:127];
    for (int i = 0; i < 128; i++) pb[i] = 8'hFF;
    foreach (offs[k]) begin
      send(OP_WRITE, {(k == offs.size() - 1) ? lastPg : pg, offs[k]}, vals[k],
           k == offs.size() - 1);
      pb[offs[k]] = vals[k];
    end
    wait_rsp(30000);
    check(rspData, vals[vals.size() - 1]);
    check({7'h00, pageError}, {7'h00, lastPg != pg});
    for (int i = 0; i < 128; i++) refMem[{pg, i[6:0]}] = pb[i];
    for (int i = 0; i < 128; i++) rd({pg, i[6:0]});
    rd({pg + 9'h001, 7'h00});
  endtask

  initial begin
    logic [6:0] offs [$];
    logic [7:0] vals [$];
    reset = 1'b1;
    cmdValid = 1'b0;
    cmdOp = OP_READ;
    cmdAddr = 16'h0000;
    cmdData = 8'h00;
    cmdLast = 1'b0;
    lastBus = 8'h00;
    lfsr = 8'h27;
    badCount = 0;
    cmpCount = 0;
    for (int i = 0; i < 65536; i++) refMem[i] = i[7:0] ^ 8'h5A;
    repeat (10) @(posedge core_clk);
    #1;
    check({chipSelectN, outputGateN, writeStrobeN, dqOe, busy, 3'h0}, 8'hE0);
    reset = 1'b0;
    repeat (6) begin
      lfsr = nxt(lfsr);
      rd({lfsr, ~lfsr});
    end
    offs = '{7'h00, 7'h7F, 7'h00, 7'h3F};
    vals = '{8'h11, 8'h22, 8'h33, 8'h44};
    wr_page(9'h0A5, offs, vals, 9'h0A6);
    offs = {};
    vals = {};
    for (int i = 0; i < 128; i++) begin
      lfsr = nxt(lfsr);
      offs.push_back(i[6:0]);
      vals.push_back(lfsr);
    end
    wr_page({1'b0, lfsr}, offs, vals, {1'b0, lfsr});
    send(OP_ERASE, 16'h0000, 8'h00, 1'b1);
    wait_rsp(30000);
    for (int i = 0; i < 65536; i++) refMem[i] = 8'hFF;
    repeat (6) begin
      lfsr = nxt(lfsr);
      rd({~lfsr, lfsr});
    end
    giveVerdict();
  end
endmodule
